//--- core/mcst_map.svh
// register offsets, field positions, reset values and timing counts of the monitor chain self-test
`ifndef MCST_MAP_SVH
`define MCST_MAP_SVH
`define MCST_OFS_SEL_A 6'h00
`define MCST_OFS_SEL_B 6'h04
`define MCST_OFS_SEL_C 6'h08
`define MCST_OFS_CTRL 6'h0c
`define MCST_OFS_AUX 6'h10
`define MCST_OFS_STAT 6'h14
`define MCST_OFS_IFLAG 6'h18
`define MCST_OFS_INIT_ERROR_FLAGS 6'h1c
`define MCST_OFS_SYSTEM_FAIL_FLAGS 6'h20
`define MCST_OFS_MON_A 6'h24
`define MCST_OFS_MON_B 6'h28
`define MCST_OFS_MON_C 6'h2c
`define MCST_OFS_SS2DLY 6'h30
`define MCST_CTRL_START 0
`define MCST_CTRL_PATH 1
`define MCST_CTRL_SINGLE 2
`define MCST_CTRL_INTP 3
`define MCST_CTRL_FAIL 4
`define MCST_CTRL_REJECT 5
`define MCST_CTRL_BUSY 6
`define MCST_AUX_OVF 0
`define MCST_AUX_TGEN 1
`define MCST_AUX_SS2EN 2
`define MCST_AUX_RECOV 3
`define MCST_IF_DONE 0
`define MCST_MONITOR_EVENT_FLAG 1
`define MCST_IF_WD 2
`define MCST_IF_ERRMON 3
`define MCST_VFAIL_BIT 2
`define MCST_ABORT_BIT 3
`define MCST_SD_MASK 24'hc10e2f
`define MCST_INT_MASK 24'h30f1d0
`define MCST_SS2DLY_RST 8'h00
`define MCST_CLK_MHZ 40
`define MCST_TRR_NS 2000
`define MCST_TRR_CYC ((`MCST_TRR_NS * `MCST_CLK_MHZ + 999) / 1000)
`define MCST_CONLY_CYC (`MCST_TRR_CYC / 2)
`define MCST_FULL_CYC (`MCST_TRR_CYC * 2)
`define MCST_ERR_TMO_US 100
`define MCST_ERR_TMO_CYC (`MCST_ERR_TMO_US * `MCST_CLK_MHZ)
`define MCST_REC_US 50
`define MCST_REC_CYC (`MCST_REC_US * `MCST_CLK_MHZ)
`define MCST_TOG_HALF_US 10
`define MCST_TOG_HALF_CYC (`MCST_TOG_HALF_US * `MCST_CLK_MHZ)
`define MCST_SS2_UNIT_CYC `MCST_CLK_MHZ
`endif

//--- core/mcst_pkg.sv
// types shared by the monitor chain self-test files
package mcst_pkg;
	typedef enum logic [2:0] {
		MCST_IDLE = 3'b001,
		MCST_RUN = 3'b010,
		MCST_HOLD = 3'b100
	} mcst_seq_t;
	typedef struct packed {
		logic init;
		logic normal;
		logic wake;
	} mcst_dstate_t;
	typedef struct packed {
		logic toInit;
		logic toWake;
		logic toFailsafe;
		logic resetOut;
	} mcst_req_t;
endpackage

//--- core/mcst_timer.sv
// loadable down counter with one-cycle expiry pulse
`timescale 1ns/1ps
module mcst_timer #(
	parameter int W = 16
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic load,
	input wire logic [W-1:0] loadValue,
	input wire logic stop,
	output logic expired
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	always_comb begin
		cnt_nxt = cnt_r;
		expired = 1'b0;
		if (load) begin
			cnt_nxt = loadValue;
		end else if (stop) begin
			cnt_nxt = '0;
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - W'(1);
			expired = (cnt_r == W'(1));
		end
	end
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule

//--- core/mcst_top.sv
// monitor chain self-test sequencer with safe-state outputs and avalon register slave
// Functional notes
// - control 07 starts single full shutdown test
// - shutdown test end: go wake, or failsafe if a FS_MASK comparator passed, done flag
// - set init or terminal_safe_state voltage fail flag
// - both outputs low, second one optionally delayed when going to wake, never when going to failsafe
// - report status, set monitor flags, clear passed selections
// - force never releases activated outputs, toggle does not block release
// - interrupt test accepted in init, normal, wake
// - control 0f starts single full interrupt test
// - interrupt test sets monitor flag, no done
// - comparator-only test aborts on severe real failure
// - full path blinds comparators, other failures abort
// - abort sets abort flag, keeps monitor results
// - host tests watchdogs and error monitor itself
// - watchdog fault: interrupt, reset, safe state, init
// - stopped alive toggle is an error-monitor fault
// - cleared selection bit means that comparator passed
`timescale 1ns/1ps
`include "mcst_map.svh"
module mcst_top #(
	parameter logic [23:0] FS_MASK = 24'hc00000
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire mcst_pkg::mcst_dstate_t devState,
	input wire logic goNormal,
	input wire logic severeFail,
	input wire logic severeToFailsafe,
	input wire logic wdFail,
	input wire logic [23:0] cmpRaw,
	input wire logic errPin,
	output logic [23:0] cmpInject,
	output logic safeStateA,
	output logic safeStateB,
	output logic intReq,
	output mcst_pkg::mcst_req_t reqOut,
	output logic toggleGenOut
);
	mcst_pkg::mcst_seq_t st_r, st_nxt;
	logic [23:0] sel_r, sel_nxt, mon_r, mon_nxt, inject_r, inject_nxt;
	logic [23:0] cmpSync1_r, cmpSync2_r, pass;
	logic errSync1_r, errSync2_r, alive, aliveLast_r, aliveEdge;
	logic [3:0] ctrl_r, ctrl_nxt, aux_r, aux_nxt, iflag_r, iflag_nxt, ifSet, ifClr;
	logic fail_r, fail_nxt, rej_r, rej_nxt;
	logic [7:0] ss2Dly_r, ss2Dly_nxt;
	logic initVFail_r, initVFail_nxt, sysVFail_r, sysVFail_nxt, abort_r, abort_nxt;
	logic activated_r, activated_nxt, pend_r, pend_nxt, ssA_r, ssA_nxt, ssB_r, ssB_nxt;
	logic recPend_r, recPend_nxt, errFault_r, errFault_nxt, togGen_r, togGen_nxt;
	logic [15:0] togDiv_r, togDiv_nxt;
	logic ack_r, ack_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	mcst_pkg::mcst_req_t req_r, req_nxt;
	logic wrStrobe, full, intp, startOk, abortNow, runDone, ss2Done, errExp;
	logic runLoad, ss2Load, errLoad, actEvent, delayed;
	logic [15:0] runLoadVal, ss2LoadVal, errLoadVal;
	logic [7:0] wByte;

	mcst_timer #(.W(16)) runTimer (
		.clk_sys(clk_sys),
		.reset(reset),
		.load(runLoad),
		.loadValue(runLoadVal),
		.stop(abortNow),
		.expired(runDone)
	);
	mcst_timer #(.W(16)) ss2Timer (
		.clk_sys(clk_sys),
		.reset(reset),
		.load(ss2Load),
		.loadValue(ss2LoadVal),
		.stop(1'b0),
		.expired(ss2Done)
	);
	mcst_timer #(.W(16)) errTimer (
		.clk_sys(clk_sys),
		.reset(reset),
		.load(errLoad),
		.loadValue(errLoadVal),
		.stop(1'b0),
		.expired(errExp)
	);

	// bus: one wait cycle, write takes effect at the edge after the one that drops waitrequest
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign avs_readdata = rdata_r;
	assign wrStrobe = avs_write & ack_r & avs_byteenable[0];
	assign wByte = avs_writedata[7:0];
	assign cmpInject = inject_r;
	assign safeStateA = ssA_r;
	assign safeStateB = ssB_r;
	assign intReq = |iflag_r;
	assign reqOut = req_r;
	assign toggleGenOut = togGen_r;
	// toggle generator replaces the pin as alive source
	assign alive = aux_r[`MCST_AUX_TGEN] ? togGen_r : errSync2_r;
	assign aliveEdge = alive ^ aliveLast_r;
	assign full = ctrl_r[`MCST_CTRL_PATH];
	assign intp = ctrl_r[`MCST_CTRL_INTP];
	assign pass = sel_r & cmpSync2_r;
	assign delayed = aux_r[`MCST_AUX_SS2EN] && ss2Dly_r != 8'h00 && !(|(pass & FS_MASK));
	assign ss2LoadVal = 16'(ss2Dly_r * `MCST_SS2_UNIT_CYC);
	assign errLoad = aliveEdge | (errExp & aux_r[`MCST_AUX_RECOV] & ~recPend_r);
	assign errLoadVal = aliveEdge ? 16'(`MCST_ERR_TMO_CYC) : 16'(`MCST_REC_CYC);

	always_comb begin
		st_nxt = st_r;
		sel_nxt = sel_r;
		mon_nxt = mon_r;
		inject_nxt = inject_r;
		ctrl_nxt = ctrl_r;
		aux_nxt = aux_r;
		fail_nxt = fail_r;
		rej_nxt = rej_r;
		ss2Dly_nxt = ss2Dly_r;
		initVFail_nxt = initVFail_r;
		sysVFail_nxt = sysVFail_r;
		abort_nxt = abort_r;
		ifSet = 4'h0;
		ifClr = 4'h0;
		req_nxt = '0;
		actEvent = 1'b0;
		pend_nxt = pend_r;
		runLoad = 1'b0;
		runLoadVal = 16'(`MCST_CONLY_CYC);
		ss2Load = 1'b0;
		abortNow = 1'b0;
		startOk = 1'b0;
		recPend_nxt = recPend_r;
		errFault_nxt = errFault_r;
		togDiv_nxt = togDiv_r;
		togGen_nxt = togGen_r;
		// register writes
		if (wrStrobe) begin
			case (avs_address)
				`MCST_OFS_SEL_A: if (st_r == mcst_pkg::MCST_IDLE) sel_nxt[7:0] = wByte;
				`MCST_OFS_SEL_B: if (st_r == mcst_pkg::MCST_IDLE) sel_nxt[15:8] = wByte;
				`MCST_OFS_SEL_C: if (st_r == mcst_pkg::MCST_IDLE) sel_nxt[23:16] = wByte;
				`MCST_OFS_AUX: aux_nxt = wByte[3:0];
				`MCST_OFS_SS2DLY: ss2Dly_nxt = wByte;
				`MCST_OFS_IFLAG: ifClr = wByte[3:0];
				`MCST_OFS_INIT_ERROR_FLAGS: if (wByte[`MCST_VFAIL_BIT]) initVFail_nxt = 1'b0;
				`MCST_OFS_SYSTEM_FAIL_FLAGS: begin
					if (wByte[`MCST_VFAIL_BIT]) sysVFail_nxt = 1'b0;
					if (wByte[`MCST_ABORT_BIT]) abort_nxt = 1'b0;
				end
				`MCST_OFS_MON_A: mon_nxt[7:0] = mon_r[7:0] & ~wByte;
				`MCST_OFS_MON_B: mon_nxt[15:8] = mon_r[15:8] & ~wByte;
				`MCST_OFS_MON_C: mon_nxt[23:16] = mon_r[23:16] & ~wByte;
				`MCST_OFS_CTRL: begin
					if (st_r == mcst_pkg::MCST_IDLE && wByte[`MCST_CTRL_START]) begin
						// full shutdown test needs normal state, others init/normal/wake
						startOk = (devState.init | devState.normal | devState.wake) &
							!(wByte[`MCST_CTRL_PATH] && !wByte[`MCST_CTRL_INTP] &&
							!devState.normal);
						ctrl_nxt = wByte[3:0];
						rej_nxt = !startOk;
						fail_nxt = 1'b0;
						if (startOk) begin
							inject_nxt = sel_r;
							runLoad = 1'b1;
							runLoadVal = wByte[`MCST_CTRL_PATH] ? 16'(`MCST_FULL_CYC) :
								16'(`MCST_CONLY_CYC);
							st_nxt = mcst_pkg::MCST_RUN;
						end
					end
				end
				default: begin
				end
			endcase
		end
		// sequencer
		case (st_r)
			mcst_pkg::MCST_IDLE: begin
			end
			mcst_pkg::MCST_RUN: begin
				// full path blinds the comparators, so only other failures abort
				abortNow = severeFail ||
					(!full && |(cmpSync2_r & ~sel_r & `MCST_SD_MASK));
				if (abortNow) begin
					// monitor results already stored stay untouched
					abort_nxt = 1'b1;
					fail_nxt = 1'b1;
					inject_nxt = '0;
					actEvent = 1'b1;
					req_nxt.resetOut = !severeToFailsafe;
					req_nxt.toFailsafe = severeToFailsafe;
					req_nxt.toInit = !severeToFailsafe;
					st_nxt = mcst_pkg::MCST_IDLE;
				end else if (runDone) begin
					sel_nxt = sel_r & ~pass;
					mon_nxt = mon_r | pass;
					fail_nxt = |(sel_r & ~pass);
					inject_nxt = '0;
					st_nxt = mcst_pkg::MCST_IDLE;
					if (full && intp) begin
						ifSet[`MCST_MONITOR_EVENT_FLAG] = |(pass & `MCST_INT_MASK);
					end else begin
						ifSet[`MCST_IF_DONE] = 1'b1;
					end
					if (full && !intp && |(pass & `MCST_SD_MASK)) begin
						if (|(pass & FS_MASK)) begin
							sysVFail_nxt = 1'b1;
							req_nxt.toFailsafe = 1'b1;
						end else begin
							initVFail_nxt = 1'b1;
							req_nxt.toWake = 1'b1;
						end
						actEvent = !delayed;
						if (delayed) begin
							pend_nxt = 1'b1;
							ss2Load = 1'b1;
							st_nxt = mcst_pkg::MCST_HOLD;
						end
					end
				end
			end
			mcst_pkg::MCST_HOLD: begin
				if (ss2Done || !pend_r) begin
					pend_nxt = 1'b0;
					st_nxt = mcst_pkg::MCST_IDLE;
				end
			end
			default: st_nxt = mcst_pkg::MCST_IDLE;
		endcase
		// watchdog fault reaction
		if (wdFail) begin
			ifSet[`MCST_IF_WD] = 1'b1;
			req_nxt.resetOut = 1'b1;
			req_nxt.toInit = 1'b1;
			actEvent = 1'b1;
		end
		// alive-signal error monitor: immediate or after recovery delay
		if (aliveEdge) begin
			recPend_nxt = 1'b0;
			errFault_nxt = 1'b0;
		end else if (errExp) begin
			if (aux_r[`MCST_AUX_RECOV] && !recPend_r) begin
				recPend_nxt = 1'b1;
				ifSet[`MCST_IF_ERRMON] = 1'b1;
			end else begin
				recPend_nxt = 1'b0;
				errFault_nxt = 1'b1;
				ifSet[`MCST_IF_ERRMON] = 1'b1;
				actEvent = 1'b1;
			end
		end
		if (togDiv_r == 16'(`MCST_TOG_HALF_CYC - 1)) begin
			togDiv_nxt = 16'h0000;
			togGen_nxt = aux_r[`MCST_AUX_TGEN] ? ~togGen_r : 1'b0;
		end else begin
			togDiv_nxt = togDiv_r + 16'h0001;
		end
		if (actEvent && st_nxt != mcst_pkg::MCST_HOLD) begin
			pend_nxt = 1'b0;
		end
		// set wins over clear
		iflag_nxt = (iflag_r & ~ifClr) | ifSet;
	end

	// safe-state outputs: only a state request may release them
	always_comb begin
		activated_nxt = activated_r | actEvent | (pend_nxt & ~pend_r);
		if (goNormal && !actEvent && !errFault_nxt && !aux_r[`MCST_AUX_OVF]) begin
			activated_nxt = 1'b0;
		end
		ssA_nxt = devState.normal & ~activated_nxt;
		ssB_nxt = ssA_nxt | (pend_nxt & ssB_r);
	end

	// bus answer
	always_comb begin
		ack_nxt = (avs_read | avs_write) & ~ack_r;
		rdata_nxt = rdata_r;
		if (avs_read && !ack_r) begin
			rdata_nxt = 32'h0000_0000;
			case (avs_address)
				`MCST_OFS_SEL_A: rdata_nxt[7:0] = sel_r[7:0];
				`MCST_OFS_SEL_B: rdata_nxt[7:0] = sel_r[15:8];
				`MCST_OFS_SEL_C: rdata_nxt[7:0] = sel_r[23:16];
				`MCST_OFS_CTRL: rdata_nxt[6:0] = {st_r != mcst_pkg::MCST_IDLE, rej_r, fail_r, ctrl_r};
				`MCST_OFS_AUX: rdata_nxt[3:0] = aux_r;
				`MCST_OFS_STAT: rdata_nxt[7:0] = {recPend_r, errFault_r, activated_r, ssB_r,
					ssA_r, st_r};
				`MCST_OFS_IFLAG: rdata_nxt[3:0] = iflag_r;
				`MCST_OFS_INIT_ERROR_FLAGS: rdata_nxt[`MCST_VFAIL_BIT] = initVFail_r;
				`MCST_OFS_SYSTEM_FAIL_FLAGS: rdata_nxt[3:2] = {abort_r, sysVFail_r};
				`MCST_OFS_MON_A: rdata_nxt[7:0] = mon_r[7:0];
				`MCST_OFS_MON_B: rdata_nxt[7:0] = mon_r[15:8];
				`MCST_OFS_MON_C: rdata_nxt[7:0] = mon_r[23:16];
				`MCST_OFS_SS2DLY: rdata_nxt[7:0] = ss2Dly_r;
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		// comparator and pin levels arrive asynchronously
		cmpSync1_r <= cmpRaw;
		cmpSync2_r <= cmpSync1_r;
		errSync1_r <= errPin;
		errSync2_r <= errSync1_r;
		if (reset) begin
			st_r <= mcst_pkg::MCST_IDLE;
			sel_r <= 24'h000000;
			mon_r <= 24'h000000;
			inject_r <= 24'h000000;
			ctrl_r <= 4'h0;
			aux_r <= 4'h0;
			fail_r <= 1'b0;
			rej_r <= 1'b0;
			ss2Dly_r <= `MCST_SS2DLY_RST;
			initVFail_r <= 1'b0;
			sysVFail_r <= 1'b0;
			abort_r <= 1'b0;
			iflag_r <= 4'h0;
			activated_r <= 1'b1;
			pend_r <= 1'b0;
			ssA_r <= 1'b0;
			ssB_r <= 1'b0;
			recPend_r <= 1'b0;
			errFault_r <= 1'b0;
			togGen_r <= 1'b0;
			togDiv_r <= 16'h0000;
			aliveLast_r <= 1'b0;
			ack_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			req_r <= '0;
		end else begin
			st_r <= st_nxt;
			sel_r <= sel_nxt;
			mon_r <= mon_nxt;
			inject_r <= inject_nxt;
			ctrl_r <= ctrl_nxt;
			aux_r <= aux_nxt;
			fail_r <= fail_nxt;
			rej_r <= rej_nxt;
			ss2Dly_r <= ss2Dly_nxt;
			initVFail_r <= initVFail_nxt;
			sysVFail_r <= sysVFail_nxt;
			abort_r <= abort_nxt;
			iflag_r <= iflag_nxt;
			activated_r <= activated_nxt;
			pend_r <= pend_nxt;
			ssA_r <= ssA_nxt;
			ssB_r <= ssB_nxt;
			recPend_r <= recPend_nxt;
			errFault_r <= errFault_nxt;
			togGen_r <= togGen_nxt;
			togDiv_r <= togDiv_nxt;
			aliveLast_r <= alive;
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
			req_r <= req_nxt;
		end
	end

	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	localparam int CONLY = `MCST_CONLY_CYC;
	start_reject_a: assert property (wrStrobe && avs_address == `MCST_OFS_CTRL && wByte == 8'h07 &&
		st_r == mcst_pkg::MCST_IDLE && !devState.normal |=> rej_r && st_r == mcst_pkg::MCST_IDLE)
		else $error("full shutdown test started outside normal");
	start_run_a: assert property (wrStrobe && avs_address == `MCST_OFS_CTRL && wByte == 8'h0f &&
		st_r == mcst_pkg::MCST_IDLE && (devState.init || devState.wake) |=> st_r == mcst_pkg::MCST_RUN &&
		cmpInject == $past(sel_r)) else $error("interrupt test not started");
	sd_done_a: assert property (st_r == mcst_pkg::MCST_RUN && runDone && !abortNow && full &&
		!intp && |(pass & `MCST_SD_MASK & ~FS_MASK) |=> req_r.toWake && iflag_r[`MCST_IF_DONE] &&
		initVFail_r && !safeStateA) else $error("shutdown test end reaction missing");
	int_done_a: assert property (st_r == mcst_pkg::MCST_RUN && runDone && !abortNow && full &&
		intp && |(pass & `MCST_INT_MASK) && !ifClr[`MCST_MONITOR_EVENT_FLAG] |=> iflag_r[`MCST_MONITOR_EVENT_FLAG] &&
		intReq && $stable(iflag_r[`MCST_IF_DONE])) else $error("interrupt test result wrong");
	sel_clear_a: assert property (st_r == mcst_pkg::MCST_RUN && runDone && !abortNow |=>
		sel_r == ($past(sel_r) & ~$past(cmpSync2_r)) && fail_r == (sel_r != 24'h000000) &&
		cmpInject == 24'h000000) else $error("selection result wrong");
	abort_flag_a: assert property (st_r == mcst_pkg::MCST_RUN && severeFail |=> abort_r &&
		$stable(mon_r) && st_r == mcst_pkg::MCST_IDLE && !safeStateA) else $error("abort missed");
	blind_a: assert property (st_r == mcst_pkg::MCST_RUN && full && !severeFail |=>
		!abort_r || $past(abort_r)) else $error("full path test aborted by comparator");
	hold_low_a: assert property (activated_r && !goNormal |=> !safeStateA)
		else $error("safe state released without request");
	ss2_delay_a: assert property ($rose(pend_r) && ssB_r |=> ssB_r [*2])
		else $error("second output dropped before delay");
	wd_react_a: assert property (wdFail |=> reqOut.resetOut && reqOut.toInit && !safeStateA &&
		iflag_r[`MCST_IF_WD]) else $error("watchdog fault reaction missing");
	run_len_a: assert property ($rose(st_r == mcst_pkg::MCST_RUN) && !full |->
		(st_r == mcst_pkg::MCST_RUN) [*2] ##[1:CONLY] st_r != mcst_pkg::MCST_RUN)
		else $error("comparator-only run length wrong");
	cover_sd: cover property (st_r == mcst_pkg::MCST_RUN ##1 req_r.toWake);
	cover_int: cover property (st_r == mcst_pkg::MCST_RUN && full && intp ##1 iflag_r[`MCST_MONITOR_EVENT_FLAG]);
	cover_abort: cover property ($rose(abort_r));
	cover_err: cover property ($rose(errFault_r));
endmodule

//--- verification/mcst_far_side.sv
// far side model: comparator outputs echoing the injection, and the device state machine
`timescale 1ns/1ps
module mcst_far_side (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [23:0] cmpInject,
	input wire mcst_pkg::mcst_req_t reqOut,
	input wire logic goNormal,
	input wire logic [23:0] stuckMask,
	input wire logic [23:0] extraMask,
	output logic [23:0] cmpRaw,
	output mcst_pkg::mcst_dstate_t devState
);
	mcst_pkg::mcst_dstate_t state_r;
	mcst_pkg::mcst_dstate_t state_nxt;
	logic [23:0] raw_r;
	logic [23:0] raw_nxt;
	always_comb begin
		state_nxt = state_r;
		// stuck bits model a dead comparator, extra bits a real out-of-range condition
		raw_nxt = (cmpInject & ~stuckMask) | extraMask;
		if (reqOut.toFailsafe) begin
			state_nxt = 3'b000;
		end else if (reqOut.toInit) begin
			state_nxt = 3'b100;
		end else if (reqOut.toWake) begin
			state_nxt = 3'b001;
		end else if (goNormal && (state_r.init || state_r.wake)) begin
			state_nxt = 3'b010;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_r <= 3'b100;
			raw_r <= 24'h000000;
		end else begin
			state_r <= state_nxt;
			raw_r <= raw_nxt;
		end
	end
	assign cmpRaw = raw_r;
	assign devState = state_r;
endmodule

//--- verification/mcst_testbench.sv
// self-checking bench for the monitor chain self-test block
`timescale 1ns/1ps
`include "mcst_map.svh"
module testbench;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	mcst_pkg::mcst_dstate_t devState;
	mcst_pkg::mcst_req_t reqOut;
	logic goNormal = 1'b0;
	logic severeFail = 1'b0;
	logic wdFail = 1'b0;
	logic errPin = 1'b0;
	logic errStop = 1'b0;
	logic [7:0] togCnt = 8'h00;
	logic [23:0] cmpRaw;
	logic [23:0] cmpInject;
	logic [23:0] stuckMask = 24'h000000;
	logic [23:0] extraMask = 24'h000000;
	logic safeStateA;
	logic safeStateB;
	logic intReq;
	logic toggleGenOut;
	int n_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	mcst_top u_dut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.devState(devState), .goNormal(goNormal), .severeFail(severeFail),
		.severeToFailsafe(1'b0), .wdFail(wdFail), .cmpRaw(cmpRaw), .errPin(errPin),
		.cmpInject(cmpInject), .safeStateA(safeStateA), .safeStateB(safeStateB),
		.intReq(intReq), .reqOut(reqOut), .toggleGenOut(toggleGenOut));
	mcst_far_side u_far (.clk_sys(clk_sys), .reset(reset), .cmpInject(cmpInject),
		.reqOut(reqOut), .goNormal(goNormal), .stuckMask(stuckMask), .extraMask(extraMask),
		.cmpRaw(cmpRaw), .devState(devState));
	always #12.5 clk_sys = ~clk_sys;
	// alive toggle well inside the error monitor window, unless a scenario stops it
	always @(posedge clk_sys) begin
		togCnt <= togCnt + 8'h01;
		if (togCnt == 8'hc7 && !errStop) begin
			errPin <= ~errPin;
			togCnt <= 8'h00;
		end
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic summarize();
		if (n_errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// one bus cycle; waitrequest and read data are taken at the rising edge, before it updates them
	task automatic xfer(input logic [5:0] a, input logic w, input logic [7:0] d,
		output logic [31:0] q);
		int k;
		k = 0;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= w;
		avs_read <= ~w;
		do begin
			@(posedge clk_sys);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 20);
		if (k >= 20) begin
			n_errors++;
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [31:0] q;
		xfer(a, 1'b1, d, q);
	endtask
	task automatic rc(input string nm, input logic [5:0] a, input logic [7:0] m,
		input logic [7:0] e);
		logic [31:0] q;
		xfer(a, 1'b0, 8'h00, q);
		chk(nm, q & {24'h000000, m}, {24'h000000, e});
	endtask
	task automatic wait_idle();
		logic [31:0] q;
		int k;
		k = 0;
		do begin
			xfer(`MCST_OFS_CTRL, 1'b0, 8'h00, q);
			k++;
		end while (q[`MCST_CTRL_BUSY] !== 1'b0 && k < 200);
		if (k >= 200) begin
			n_errors++;
		end
	endtask
	task automatic pulse_normal();
		@(posedge clk_sys);
		goNormal <= 1'b1;
		@(posedge clk_sys);
		goNormal <= 1'b0;
	endtask
	task automatic clr_flags();
		wr(`MCST_OFS_IFLAG, 8'hff);
		wr(`MCST_OFS_INIT_ERROR_FLAGS, 8'hff);
		wr(`MCST_OFS_SYSTEM_FAIL_FLAGS, 8'hff);
		wr(`MCST_OFS_MON_A, 8'hff);
		wr(`MCST_OFS_MON_B, 8'hff);
		wr(`MCST_OFS_MON_C, 8'hff);
	endtask
	task automatic go_normal();
		pulse_normal();
		cyc(2);
		pulse_normal();
		cyc(4);
		chk("ssA high", 32'(safeStateA), 1);
		chk("ssB high", 32'(safeStateB), 1);
	endtask
	task automatic t_reset();
		rc("stat", `MCST_OFS_STAT, 8'hff, 8'h21);
		rc("selA", `MCST_OFS_SEL_A, 8'hff, 8'h00);
		wr(6'h3c, 8'h5a);
		rc("unmapped", 6'h3c, 8'hff, 8'h00);
	endtask
	task automatic t_shutdown();
		logic [31:0] q;
		int k;
		go_normal();
		clr_flags();
		wr(`MCST_OFS_SS2DLY, 8'h02);
		wr(`MCST_OFS_AUX, 8'h04);
		wr(`MCST_OFS_SEL_A, 8'h01);
		wr(`MCST_OFS_CTRL, 8'h07);
		// the second output is only still high while the delay runs
		k = 0;
		do begin
			xfer(`MCST_OFS_STAT, 1'b0, 8'h00, q);
			k++;
		end while (q[2:0] !== 3'b100 && k < 200);
		if (k >= 200) begin
			n_errors++;
		end
		chk("ssA low", 32'(safeStateA), 0);
		chk("ssB delayed", 32'(safeStateB), 1);
		wait_idle();
		chk("ssB low", 32'(safeStateB), 0);
		chk("wake", 32'(devState.wake), 1);
		chk("int", 32'(intReq), 1);
		rc("iflag done", `MCST_OFS_IFLAG, 8'h01, 8'h01);
		rc("ctrl", `MCST_OFS_CTRL, 8'hff, 8'h07);
		rc("selA", `MCST_OFS_SEL_A, 8'hff, 8'h00);
		rc("monA", `MCST_OFS_MON_A, 8'hff, 8'h01);
		rc("init_error_flags", `MCST_OFS_INIT_ERROR_FLAGS, 8'h04, 8'h04);
		rc("system_fail_flags", `MCST_OFS_SYSTEM_FAIL_FLAGS, 8'h04, 8'h00);
	endtask
	task automatic t_hold();
		logic [7:0] steps [4];
		steps = '{8'h01, 8'h03, 8'h01, 8'h00};
		for (int i = 0; i < 4; i++) begin
			wr(`MCST_OFS_AUX, steps[i]);
			// a release request only while the force is on, so the last step stays quiet
			if (i < 3) begin
				pulse_normal();
			end
			cyc(2000);
			chk("ssA held", 32'(safeStateA), 0);
			chk("ssB held", 32'(safeStateB), 0);
		end
	endtask
	task automatic t_wd();
		go_normal();
		clr_flags();
		@(posedge clk_sys);
		wdFail <= 1'b1;
		@(posedge clk_sys);
		wdFail <= 1'b0;
		cyc(6);
		chk("ssA wd", 32'(safeStateA), 0);
		chk("init wd", 32'(devState.init), 1);
		rc("iflag wd", `MCST_OFS_IFLAG, 8'h04, 8'h04);
	endtask
	task automatic t_int();
		clr_flags();
		chk("int clear", 32'(intReq), 0);
		wr(`MCST_OFS_SEL_B, 8'h01);
		wr(`MCST_OFS_CTRL, 8'h0f);
		extraMask <= 24'h000001;
		cyc(100);
		extraMask <= 24'h000000;
		wait_idle();
		chk("int set", 32'(intReq), 1);
		rc("iflag mon", `MCST_OFS_IFLAG, 8'h03, 8'h02);
		rc("ctrl int", `MCST_OFS_CTRL, 8'hff, 8'h0f);
		rc("monB", `MCST_OFS_MON_B, 8'hff, 8'h01);
		rc("selB", `MCST_OFS_SEL_B, 8'hff, 8'h00);
		rc("no abort", `MCST_OFS_SYSTEM_FAIL_FLAGS, 8'h08, 8'h00);
	endtask
	task automatic t_reject();
		wr(`MCST_OFS_SEL_A, 8'h01);
		wr(`MCST_OFS_CTRL, 8'h07);
		cyc(3);
		rc("rejected", `MCST_OFS_CTRL, 8'hff, 8'h27);
		rc("stat idle", `MCST_OFS_STAT, 8'h07, 8'h01);
		wr(`MCST_OFS_SEL_A, 8'h00);
	endtask
	task automatic t_fail();
		stuckMask <= 24'h010000;
		wr(`MCST_OFS_SEL_C, 8'h01);
		wr(`MCST_OFS_CTRL, 8'h05);
		wait_idle();
		stuckMask <= 24'h000000;
		rc("ctrl fail", `MCST_OFS_CTRL, 8'hff, 8'h15);
		rc("selC kept", `MCST_OFS_SEL_C, 8'hff, 8'h01);
		rc("monC", `MCST_OFS_MON_C, 8'hff, 8'h00);
		wr(`MCST_OFS_SEL_C, 8'h00);
	endtask
	task automatic t_abort();
		for (int i = 0; i < 2; i++) begin
			clr_flags();
			wr(`MCST_OFS_SEL_A, 8'h02);
			wr(`MCST_OFS_CTRL, 8'h05);
			cyc(5);
			if (i == 0) begin
				severeFail <= 1'b1;
				@(posedge clk_sys);
				severeFail <= 1'b0;
			end else begin
				extraMask <= 24'h000001;
			end
			wait_idle();
			extraMask <= 24'h000000;
			rc("abort", `MCST_OFS_SYSTEM_FAIL_FLAGS, 8'h08, 8'h08);
			chk("init abort", 32'(devState.init), 1);
			wr(`MCST_OFS_SEL_A, 8'h00);
		end
	endtask
	task automatic t_err();
		go_normal();
		clr_flags();
		errStop <= 1'b1;
		cyc(4300);
		chk("ssA err", 32'(safeStateA), 0);
		rc("iflag err", `MCST_OFS_IFLAG, 8'h08, 8'h08);
		errStop <= 1'b0;
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		t_reset();
		t_shutdown();
		t_hold();
		t_wd();
		t_int();
		t_reject();
		t_fail();
		t_abort();
		t_err();
		summarize();
	end
endmodule
